// File: rcco_pkg.sv
// Constants and carrier types for the reset cause and clock output block.
package rcco_pkg;

	// Register bus geometry and answers.
	localparam int unsigned AXI_AW      = 8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Register map; the status register index is scaled to a word address.
	localparam logic [7:0] IDX_STATUS    = 8'h03;
	localparam logic [7:0] ADDR_STATUS   = {IDX_STATUS[5:0], 2'b00};
	localparam logic [7:0] ADDR_OSC_CFG  = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
	localparam logic [7:0] ADDR_RETAIN   = 8'h2C;
	localparam logic [7:0] ADDR_RST_INFO = 8'h30;

	// Status register layout from bit 7 down to bit 0.
	typedef struct packed {
		logic [2:0] page_select;
		logic       timeout_flag;
		logic       powerdown_flag;
		logic       zero_flag;
		logic       digit_carry_flag;
		logic       carry_flag;
	} rcco_status_s;

	// Cause flag values per reset source.
	localparam logic [2:0] PAGE_RST      = 3'h0;
	localparam logic       POR_TO        = 1'b1;
	localparam logic       POR_PD        = 1'b1;
	localparam logic       MASTER_CLEAR_PIN_WAKE_TO  = 1'b1;
	localparam logic       MASTER_CLEAR_PIN_WAKE_PD  = 1'b0;
	localparam logic       WDT_RUN_TO    = 1'b0;
	localparam logic       WDT_RUN_PD    = 1'b1;
	localparam logic       WDT_WAKE_TO   = 1'b0;
	localparam logic       WDT_WAKE_PD   = 1'b0;

	// Reset events, one sticky interrupt bit each.
	typedef struct packed {
		logic wdt_wake;
		logic wdt_run;
		logic master_clear_pin_wake;
		logic master_clear_pin_run;
		logic por;
	} rcco_event_s;

	// Oscillator mode field encodings and reset value.
	localparam logic [1:0] OSC_MODE_LP  = 2'h0;
	localparam logic [1:0] OSC_MODE_XT  = 2'h1;
	localparam logic [1:0] OSC_MODE_HS  = 2'h2;
	localparam logic [1:0] OSC_MODE_RC  = 2'h3;
	localparam logic [1:0] OSC_MODE_RST = OSC_MODE_RC;

	// Timing.
	localparam int unsigned CLK_FREQ_MHZ = 40;
	localparam int unsigned DRT_TIME_US  = 18000;
	localparam int unsigned DRT_CYCLES_DEF = DRT_TIME_US * CLK_FREQ_MHZ;
	localparam int unsigned CLK_DIV      = 4;

	typedef enum logic [1:0] {
		RCCO_HOLD,
		RCCO_TIMER,
		RCCO_RUN
	} rcco_state_e;

endpackage

// File: rcco_top.sv
// Reset cause recorder, device reset timer and divided clock output.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Five reset sources are recognised.
// - Wake-up from halt is a full reset.
// - Retained register is never reset.
// - Other registers but the arithmetic flags take reset values.
// - Timeout and powerdown flags at bits 4:3.
// - Run-time master clear keeps both flags.
// - Master clear wake: timeout 1, powerdown 0.
// - Watchdog run reset: timeout 0, powerdown 1.
// - Watchdog wake: both flags cleared.
// - Power-on status reads 0001 1xxx.
// - Other resets: 000q quuu status.
// - RC mode drives oscillator divided by four.
// - Two-bit field selects oscillator mode.
// - Reset timer holds core after pin high.
// - Watchdog timeout restarts the reset timer.
module rcco_top
	import rcco_pkg::*;
#(
	parameter int unsigned DRT_CYCLES = DRT_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// Register bus.
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Board pins.
	input  wire logic              master_clear_pin_n,
	output logic                   oscillator_output_pin,
	output logic                   oscillator_output_pin_oe,
	// Core side.
	input  wire logic              watchdog_timeout,
	input  wire logic              core_sleeping,
	output logic                   core_reset,
	output logic                   irq
);

	localparam int unsigned CNT_W = (DRT_CYCLES > 2) ? $clog2(DRT_CYCLES) : 1;
	localparam logic [CNT_W-1:0] DRT_LAST = CNT_W'(DRT_CYCLES - 1);
	localparam int unsigned DIV_W = $clog2(CLK_DIV);

	logic              master_clear_pin_meta_r;
	logic              master_clear_pin_sync_r;
	logic              por_pend_r;
	rcco_state_e       state_r;
	rcco_state_e       state_nxt;
	logic [CNT_W-1:0]  drt_cnt_r;
	logic [CNT_W-1:0]  drt_cnt_nxt;
	logic              core_reset_r;
	logic [2:0]        page_r;
	logic [2:0]        page_nxt;
	logic              to_r;
	logic              to_nxt;
	logic              pd_r;
	logic              pd_nxt;
	logic [2:0]        arith_r;
	logic [7:0]        retain_r;
	logic [1:0]        osc_mode_r;
	rcco_event_s       irq_stat_r;
	rcco_event_s       irq_mask_r;
	logic [DIV_W-1:0]  div_cnt_r;
	logic              osc_out_r;
	logic              osc_oe_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [1:0]        rresp_r;
	logic [31:0]       rdata_r;

	// Master-clear pin synchroniser; the first stage feeds only the second.
	// It resets low so that the core stays held until the pin is seen high.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			master_clear_pin_meta_r <= 1'b0;
			master_clear_pin_sync_r <= 1'b0;
		end else begin
			master_clear_pin_meta_r <= master_clear_pin_n;
			master_clear_pin_sync_r <= master_clear_pin_meta_r;
		end
	end

	// Reset source classification; all sources but power-on only while the core is running.
	wire         run_w      = (state_r == RCCO_RUN);
	wire         master_clear_pin_low_w = ~master_clear_pin_sync_r;
	wire         wdt_hit_w  = run_w & ~master_clear_pin_low_w & watchdog_timeout;
	rcco_event_s ev;
	assign ev.por       = por_pend_r;
	assign ev.master_clear_pin_run  = run_w & master_clear_pin_low_w & ~core_sleeping;
	assign ev.master_clear_pin_wake = run_w & master_clear_pin_low_w & core_sleeping;
	assign ev.wdt_run   = wdt_hit_w & ~core_sleeping;
	assign ev.wdt_wake  = wdt_hit_w & core_sleeping;
	wire core_ev_w = ev.master_clear_pin_run | ev.master_clear_pin_wake | ev.wdt_run | ev.wdt_wake;

	// Reset hold and device reset timer.
	always_comb begin
		state_nxt   = state_r;
		drt_cnt_nxt = drt_cnt_r;
		unique case (state_r)
			RCCO_HOLD: begin
				drt_cnt_nxt = '0;
				if (!master_clear_pin_low_w) begin
					state_nxt = RCCO_TIMER;
				end
			end
			RCCO_TIMER: begin
				if (master_clear_pin_low_w) begin
					state_nxt   = RCCO_HOLD;
					drt_cnt_nxt = '0;
				end else if (drt_cnt_r == DRT_LAST) begin
					state_nxt = RCCO_RUN;
				end else begin
					drt_cnt_nxt = drt_cnt_r + CNT_W'(1);
				end
			end
			RCCO_RUN: begin
				// Wake-ups restart from reset, never from where the core halted.
				if (master_clear_pin_low_w) begin
					state_nxt = RCCO_HOLD;
				end else if (watchdog_timeout) begin
					state_nxt   = RCCO_TIMER;
					drt_cnt_nxt = '0;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r      <= RCCO_HOLD;
			drt_cnt_r    <= '0;
			core_reset_r <= 1'b1;
			por_pend_r   <= 1'b1;
		end else begin
			state_r      <= state_nxt;
			drt_cnt_r    <= drt_cnt_nxt;
			core_reset_r <= (state_nxt != RCCO_RUN);
			por_pend_r   <= 1'b0;
		end
	end
	assign core_reset = core_reset_r;

	// Register bus decode.
	wire wr_go_w   = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	wire rd_go_w   = s_axi_arvalid & ~rvalid_r;
	wire wr_lane_w = wr_go_w & s_axi_wstrb[0];
	wire wr_status_w = wr_lane_w & (s_axi_awaddr == ADDR_STATUS);
	wire wr_cfg_w    = wr_lane_w & (s_axi_awaddr == ADDR_OSC_CFG);
	wire wr_istat_w  = wr_lane_w & (s_axi_awaddr == ADDR_IRQ_STAT);
	wire wr_imask_w  = wr_lane_w & (s_axi_awaddr == ADDR_IRQ_MASK);
	wire wr_retain_w = wr_lane_w & (s_axi_awaddr == ADDR_RETAIN);
	wire wr_hit_w = (s_axi_awaddr == ADDR_STATUS) | (s_axi_awaddr == ADDR_OSC_CFG)
		| (s_axi_awaddr == ADDR_IRQ_STAT) | (s_axi_awaddr == ADDR_IRQ_MASK)
		| (s_axi_awaddr == ADDR_RETAIN) | (s_axi_awaddr == ADDR_RST_INFO);
	assign s_axi_awready = wr_go_w;
	assign s_axi_wready  = wr_go_w;
	assign s_axi_arready = rd_go_w;

	// Cause flags change only through reset events, never by a bus write.
	assign to_nxt = ev.master_clear_pin_wake ? MASTER_CLEAR_PIN_WAKE_TO :
		ev.wdt_run ? WDT_RUN_TO :
		ev.wdt_wake ? WDT_WAKE_TO : to_r;
	assign pd_nxt = ev.master_clear_pin_wake ? MASTER_CLEAR_PIN_WAKE_PD :
		ev.wdt_run ? WDT_RUN_PD :
		ev.wdt_wake ? WDT_WAKE_PD : pd_r;
	assign page_nxt = core_ev_w ? PAGE_RST :
		wr_status_w ? s_axi_wdata[7:5] : page_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			page_r <= PAGE_RST;
			to_r   <= POR_TO;
			pd_r   <= POR_PD;
		end else begin
			page_r <= page_nxt;
			to_r   <= to_nxt;
			pd_r   <= pd_nxt;
		end
	end

	// Arithmetic flags and the retained register have no reset at all, so
	// they are undefined after power-on and survive every later reset.
	always_ff @(posedge sys_clk) begin
		if (wr_status_w) begin
			arith_r <= s_axi_wdata[2:0];
		end
		if (wr_retain_w) begin
			retain_r <= s_axi_wdata[7:0];
		end
	end

	rcco_status_s status_view;
	assign status_view = '{page_select: page_r, timeout_flag: to_r,
		powerdown_flag: pd_r, zero_flag: arith_r[2],
		digit_carry_flag: arith_r[1], carry_flag: arith_r[0]};

	// Oscillator mode field and interrupt registers.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			osc_mode_r <= OSC_MODE_RST;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			if (wr_cfg_w) begin
				osc_mode_r <= s_axi_wdata[1:0];
			end
			// A new event in the clearing cycle wins over the clear.
			irq_stat_r <= (wr_istat_w ? (irq_stat_r & ~s_axi_wdata[4:0]) : irq_stat_r)
				| ev;
			if (wr_imask_w) begin
				irq_mask_r <= s_axi_wdata[4:0];
			end
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// Clock output. Only RC mode drives the pin; in the crystal modes the pin
	// belongs to the resonator or is left open for an external clock input.
	wire rc_mode_w = (osc_mode_r == OSC_MODE_RC);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_cnt_r <= '0;
			osc_out_r <= 1'b0;
			osc_oe_r  <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_r + DIV_W'(1);
			osc_out_r <= rc_mode_w & div_cnt_r[DIV_W-1];
			osc_oe_r  <= rc_mode_w;
		end
	end
	assign oscillator_output_pin    = osc_out_r;
	assign oscillator_output_pin_oe = osc_oe_r;

	// Read mux.
	wire [AXI_AW-1:0] ra = s_axi_araddr;
	wire rd_hit_w = (ra == ADDR_STATUS) | (ra == ADDR_OSC_CFG) | (ra == ADDR_IRQ_STAT)
		| (ra == ADDR_IRQ_MASK) | (ra == ADDR_RETAIN) | (ra == ADDR_RST_INFO);
	wire [7:0] rd_byte_w =
		(ra == ADDR_STATUS)   ? status_view :
		(ra == ADDR_OSC_CFG)  ? {6'h00, osc_mode_r} :
		(ra == ADDR_IRQ_STAT) ? {3'h0, irq_stat_r} :
		(ra == ADDR_IRQ_MASK) ? {3'h0, irq_mask_r} :
		(ra == ADDR_RETAIN)   ? retain_r :
		(ra == ADDR_RST_INFO) ? {5'h00, state_r, core_reset_r} : 8'h00;

	// Responses; one write and one read can be outstanding at a time.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else begin
			if (wr_go_w) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_go_w) begin
				rvalid_r <= 1'b1;
				rresp_r  <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
				rdata_r  <= {24'h00_0000, rd_byte_w};
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_por_status: assert property ($past(sys_rst) |->
		page_r == 3'h0 && to_r && pd_r)
		else $error("Power-on status value wrong.");
	chk_master_clear_pin_run_keep: assert property (ev.master_clear_pin_run |=>
		to_r == $past(to_r) && pd_r == $past(pd_r) && page_r == 3'h0)
		else $error("Run master clear changed cause flags.");
	chk_master_clear_pin_wake_flags: assert property (ev.master_clear_pin_wake |=>
		to_r && !pd_r && core_reset)
		else $error("Master clear wake flags wrong.");
	chk_wdt_run_flags: assert property (ev.wdt_run |=>
		!to_r && pd_r && page_r == 3'h0)
		else $error("Watchdog run flags wrong.");
	chk_wdt_wake_flags: assert property (ev.wdt_wake |=>
		!to_r && !pd_r)
		else $error("Watchdog wake flags wrong.");
	chk_wake_full_reset: assert property ((ev.master_clear_pin_wake || ev.wdt_wake) |=>
		core_reset && state_r != RCCO_RUN)
		else $error("Wake-up did not reset the core.");
	chk_wdt_timer_start: assert property (ev.wdt_run |=>
		state_r == RCCO_TIMER && drt_cnt_r == '0)
		else $error("Watchdog did not restart the timer.");
	chk_drt_length: assert property ($fell(core_reset) |->
		$past(drt_cnt_r) == DRT_LAST && $past(state_r) == RCCO_TIMER)
		else $error("Reset released before timer expiry.");
	chk_flags_readonly: assert property (!core_ev_w |=>
		$stable(to_r) && $stable(pd_r))
		else $error("Cause flags changed without a reset.");
	chk_retain_kept: assert property ((core_ev_w && !wr_retain_w) |=>
		$stable(retain_r))
		else $error("Retained register disturbed by reset.");
	chk_clkout_shape: assert property (($rose(oscillator_output_pin) && rc_mode_w
		&& $stable(rc_mode_w)) |-> ##1 oscillator_output_pin ##1
		(!oscillator_output_pin || !rc_mode_w))
		else $error("Clock output is not a divide by four.");
	chk_crystal_release: assert property (!rc_mode_w |=>
		!oscillator_output_pin_oe)
		else $error("Pin driven in a crystal mode.");

	cov_master_clear_pin_wake: cover property (ev.master_clear_pin_wake ##[1:40] !core_reset);
	cov_wdt_wake: cover property (ev.wdt_wake);
	cov_irq_raise: cover property ($rose(irq));
	cov_clear_race: cover property (wr_istat_w && core_ev_w);

endmodule

`default_nettype wire

// File: rcco_board.sv
// Board reset circuitry model driving the master-clear pin of the block.
`timescale 1ns/1ps
`default_nettype none
module rcco_board #(
	parameter int unsigned RELEASE_CYCLES = 6
) (
	// Clock.
	input  wire logic sys_clk,
	// Button command from the bench.
	input  wire logic press,
	// Pin toward the device.
	output logic      master_clear_pin_n
);
	// The RC network holds the pin low after power-up and after the button is let go.
	logic [7:0] hold_r = 8'h12;

	always_ff @(posedge sys_clk) begin
		if (press) begin
			hold_r <= 8'(RELEASE_CYCLES);
		end else if (hold_r != 8'h00) begin
			hold_r <= hold_r - 8'h01;
		end
	end

	// The pin has a pull-up, so a released line reads high.
	assign master_clear_pin_n = !press && (hold_r == 8'h00);
endmodule
`default_nettype wire

// File: rcco_top_tb.sv
// Self-checking bench for the reset cause and clock output block.
`timescale 1ns/1ps
`default_nettype none
module rcco_top_tb
	import rcco_pkg::*;
;
	typedef struct packed {
		logic       is_wdt;
		logic       sleep;
		logic       to;
		logic       pd;
		logic [4:0] ev;
	} rcco_row_s;

	// A short reset timer keeps every hold within a few dozen cycles.
	localparam int unsigned DEVICE_RESET_TIMER = 16;

	logic              sys_clk               = 1'b0;
	logic              sys_rst               = 1'b1;
	logic [AXI_AW-1:0] s_axi_awaddr          = '0;
	logic              s_axi_awvalid         = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata           = '0;
	logic [3:0]        s_axi_wstrb           = 4'hF;
	logic              s_axi_wvalid          = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready          = 1'b0;
	logic [AXI_AW-1:0] s_axi_araddr          = '0;
	logic              s_axi_arvalid         = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready          = 1'b0;
	logic              master_clear_pin_n;
	logic              oscillator_output_pin;
	logic              oscillator_output_pin_oe;
	logic              watchdog_timeout      = 1'b0;
	logic              core_sleeping         = 1'b0;
	logic              core_reset;
	logic              irq;
	logic              press                 = 1'b0;
	logic              pto                   = 1'b1;
	logic              ppd                   = 1'b1;
	logic [7:0]        samp;
	logic [31:0]       exp_v;
	logic [31:0]       rdv;
	logic [1:0]        rsp;
	rcco_row_s         row;
	int                bad_count             = 0;
	int                n_tests               = 0;

	// Each row is one reset event with the cause flags that it must leave behind.
	rcco_row_s rows [6] = '{
		'{1'b1, 1'b0, 1'b0, 1'b1, 5'h08},
		'{1'b0, 1'b0, 1'b0, 1'b1, 5'h02},
		'{1'b0, 1'b1, 1'b1, 1'b0, 5'h04},
		'{1'b0, 1'b0, 1'b1, 1'b0, 5'h02},
		'{1'b1, 1'b1, 1'b0, 1'b0, 5'h10},
		'{1'b0, 1'b0, 1'b0, 1'b0, 5'h02}
	};

	// An external clock source stands in for the crystal.
	always #12.5 sys_clk = ~sys_clk;

	rcco_top #(.DRT_CYCLES(DEVICE_RESET_TIMER)) rcco_top_inst (.sys_clk, .sys_rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .master_clear_pin_n, .oscillator_output_pin,
		.oscillator_output_pin_oe, .watchdog_timeout, .core_sleeping, .core_reset, .irq);

	rcco_board #(.RELEASE_CYCLES(6)) rcco_board_inst (.sys_clk, .press, .master_clear_pin_n);

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h got %h", what, exp, got);
		end
	endtask

	// The extra edge at the end keeps a following call from driving the same strobe twice.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge sys_clk);
		while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1) @(posedge sys_clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge sys_clk);
		while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge sys_clk);
		while (s_axi_arready !== 1'b1) @(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		@(posedge sys_clk);
		while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	// Undefined arithmetic flags are masked off so that only defined bits are judged.
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] mask);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
		chk(what, exp, d & mask);
	endtask

	task automatic run_len(input string what, input int unsigned lim);
		int unsigned len;
		len = 0;
		while (core_reset !== 1'b0) begin
			len++;
			@(posedge sys_clk);
		end
		chk(what, 32'h1, 32'((len >= DEVICE_RESET_TIMER) && (len <= DEVICE_RESET_TIMER + lim)));
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		run_len("power-on hold", 40);
		rchk("power-on status", ADDR_STATUS, 32'h18, 32'hF8);
		rchk("power-on event", ADDR_IRQ_STAT, 32'h01, 32'h1F);
		chk("irq masked", 32'h0, {31'h0, irq});
		wok(ADDR_IRQ_MASK, 32'h1F);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wok(ADDR_IRQ_STAT, 32'h1F);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wok(ADDR_RETAIN, 32'h5A);
		$display("test power_on done");
		for (int i = 0; i < 6; i++) begin
			row = rows[i];
			wok(ADDR_STATUS, 32'hE5);
			exp_v = {24'h0, 3'h7, pto, ppd, 3'h5};
			rchk("flags on write", ADDR_STATUS, exp_v, 32'hFF);
			core_sleeping <= row.sleep;
			if (row.is_wdt) begin
				watchdog_timeout <= 1'b1;
				@(posedge sys_clk);
				watchdog_timeout <= 1'b0;
			end else begin
				press <= 1'b1;
			end
			while (core_reset !== 1'b1) @(posedge sys_clk);
			press <= 1'b0;
			core_sleeping <= 1'b0;
			run_len("reset hold", 16);
			exp_v = {24'h0, 3'h0, row.to, row.pd, 3'h5};
			rchk("status", ADDR_STATUS, exp_v, 32'hFF);
			rchk("event bit", ADDR_IRQ_STAT, {27'h0, row.ev}, 32'h1F);
			wok(ADDR_IRQ_MASK, 32'h1F);
			chk("irq raised", 32'h1, {31'h0, irq});
			wok(ADDR_IRQ_STAT, 32'h1F);
			chk("irq cleared", 32'h0, {31'h0, irq});
			rchk("retained", ADDR_RETAIN, 32'h5A, 32'hFF);
			pto = row.to;
			ppd = row.pd;
			$display("test reset row %0d done", i);
		end
		rd(8'h40, rdv, rsp);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		chk("unmapped data", 32'h0, rdv);
		wr(8'h40, 32'hFF, rsp);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		$display("test unmapped done");
		for (int m = 0; m < 4; m++) begin
			wok(ADDR_OSC_CFG, 32'(m));
			repeat (2) @(posedge sys_clk);
			chk("output enable", 32'(m == 3), {31'h0, oscillator_output_pin_oe});
			if (m < 3) begin
				chk("idle clock out", 32'h0, {31'h0, oscillator_output_pin});
			end
		end
		for (int k = 0; k < 8; k++) begin
			samp[k] = oscillator_output_pin;
			@(posedge sys_clk);
		end
		for (int k = 0; k < 6; k++) begin
			chk("clock out phase", {31'h0, ~samp[k]}, {31'h0, samp[k + 2]});
		end
		$display("test clock out done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		run_len("second power-on hold", 40);
		rchk("second power-on status", ADDR_STATUS, 32'h18, 32'hF8);
		rchk("retained over power-on", ADDR_RETAIN, 32'h5A, 32'hFF);
		$display("test second reset done");
		print_verdict();
	end

	// The whole run takes well under two thousand cycles; this limit is ten times that.
	initial begin
		#(20000 * 25);
		bad_count++;
		$display("[FAIL] run length expected finish got hang");
		print_verdict();
	end
endmodule
`default_nettype wire
